/* File: ssp_hold_ctrl.sv */
// hold-control slice of a serial port: i2c slave receive with clock stretch, spi receive
// with overwrite, start/stop interrupts and the nine byte registers
// assumes a plain strobe register port; scl/sda/sck/sdi come from pins
`timescale 1ns/1ns
module ssp_hold_ctrl
	import ssp_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             scl_o,
	output logic             scl_oe_n_o,
	input  wire logic        sck_i,
	input  wire logic        sdi_i,
	output logic             irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	// pin conditioning
	logic scl_s;   // synchronised scl
	logic sda_s;   // synchronised sda
	logic sck_s;   // synchronised spi clock
	logic sdi_s;   // synchronised spi data
	logic scl_r;   // scl rising
	logic scl_f;   // scl falling
	logic sck_r;   // spi clock rising
	logic sda_r;   // sda rising
	logic sda_f;   // sda falling

	ssp_sync u_sync_scl (.mclk_i(mclk_i), .nrst_i(nrst_i), .pin_i(scl_i), .level_o(scl_s));
	ssp_sync u_sync_sda (.mclk_i(mclk_i), .nrst_i(nrst_i), .pin_i(sda_i), .level_o(sda_s));
	ssp_sync u_sync_sck (.mclk_i(mclk_i), .nrst_i(nrst_i), .pin_i(sck_i), .level_o(sck_s));
	ssp_sync u_sync_sdi (.mclk_i(mclk_i), .nrst_i(nrst_i), .pin_i(sdi_i), .level_o(sdi_s));
	ssp_edge u_edge_scl (.mclk_i(mclk_i), .nrst_i(nrst_i), .lvl_i(scl_s), .rise_o(scl_r), .fall_o(scl_f));
	ssp_edge u_edge_sck (.mclk_i(mclk_i), .nrst_i(nrst_i), .lvl_i(sck_s), .rise_o(sck_r), .fall_o());
	ssp_edge u_edge_sda (.mclk_i(mclk_i), .nrst_i(nrst_i), .lvl_i(sda_s), .rise_o(sda_r), .fall_o(sda_f));

	////////////////////////////////////////////////////////////////////////////////
	// state
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,   // no frame
		ST_ADDR = 3'b010,   // receiving address byte
		ST_DATA = 3'b100    // receiving data bytes
	} phase_t;

	typedef struct packed {
		phase_t     phase;     // byte kind being received
		logic [3:0] bitcnt;    // bits seen in this byte
		logic [7:0] shift;     // receive shifter
		logic [7:0] buf_r;     // serial_data_buffer
		logic [7:0] add_r;     // slave_address_or_baud
		logic [7:0] msk_r;     // address_match_mask
		logic [7:0] stat_r;    // port_status
		logic [7:0] con1_r;    // port_control_one
		logic [7:0] con2_r;    // port_control_two
		logic [7:0] con3_r;    // port_control_three
		logic [IRQ_W-1:0] ist; // sticky interrupt status
		logic [IRQ_W-1:0] imk; // interrupt mask
		logic [7:0] rdata;     // read data register
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [3:0] port_mode_select;  // mode field of control one
	logic       i2c_slv;           // i2c slave active
	logic       spi_mode;          // spi active
	logic       sp_explicit;       // mode already detects start/stop
	logic       start_det;         // start on bus
	logic       stop_det;          // stop on bus
	logic       byte_done;         // eighth falling scl
	logic       spi_byte;          // eighth spi bit sampled
	logic [7:0] spi_word;          // completed spi byte

	assign port_mode_select = s_q.con1_r[3:0];
	assign i2c_slv     = is_i2c_slave(port_mode_select);
	assign spi_mode    = is_spi(port_mode_select);
	assign sp_explicit = (port_mode_select == MODE_SLV7_SP) || (port_mode_select == MODE_SLV10_SP)
		|| (port_mode_select == MODE_SLV7_SPX);
	assign start_det   = i2c_slv && scl_s && sda_f;
	assign stop_det    = i2c_slv && scl_s && sda_r;
	assign byte_done   = i2c_slv && scl_f && (s_q.phase != ST_IDLE) && (s_q.bitcnt == BIT_ACK);
	assign spi_byte    = spi_mode && sck_r && (s_q.bitcnt == BIT_LAST);
	assign spi_word    = {s_q.shift[6:0], sdi_s};

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic hold_evt;   // hold requested at this byte end
		logic new_byte;   // a byte is ready for the buffer
		logic [7:0] nb;   // that byte
		hold_evt = 1'b0;
		new_byte = 1'b0;
		nb       = ZERO8;
		s_d      = s_q;
		s_d.rdata = ZERO8;

		// register reads, one cycle latency; unmapped reads zero
		if (rd_i) begin
			case (addr_i)
				ADDR_BUF: begin
					s_d.rdata = s_q.buf_r;
					s_d.stat_r[STAT_BF] = 1'b0; // reading empties the buffer
				end
				ADDR_ADD:     s_d.rdata = s_q.add_r;
				ADDR_MSK:     s_d.rdata = s_q.msk_r;
				ADDR_STAT:    s_d.rdata = s_q.stat_r;
				ADDR_CON1:    s_d.rdata = s_q.con1_r;
				ADDR_CON2:    s_d.rdata = s_q.con2_r;
				ADDR_CON3:    s_d.rdata = s_q.con3_r;
				ADDR_IRQ_ST:  s_d.rdata = {{(8-IRQ_W){1'b0}}, s_q.ist};
				ADDR_IRQ_MSK: s_d.rdata = {{(8-IRQ_W){1'b0}}, s_q.imk};
				default:      s_d.rdata = ZERO8;
			endcase
		end

		// register writes; hardware events below override them
		if (wr_i) begin
			case (addr_i)
				ADDR_BUF:     s_d.buf_r = wdata_i;
				ADDR_ADD:     s_d.add_r = wdata_i;
				ADDR_MSK:     s_d.msk_r = wdata_i;
				ADDR_CON1:    s_d.con1_r = (wdata_i & CON1_WMASK) | (s_q.con1_r & ~CON1_WMASK)
					& ~(wdata_i & ~CON1_WMASK & s_q.con1_r); // overflow cleared by writing zero is kept simple
				ADDR_CON2:    s_d.con2_r = wdata_i;
				ADDR_CON3:    s_d.con3_r = (wdata_i & CON3_WMASK) | (s_q.con3_r & ~CON3_WMASK);
				ADDR_IRQ_ST:  s_d.ist = s_q.ist & ~wdata_i[IRQ_W-1:0];
				ADDR_IRQ_MSK: s_d.imk = wdata_i[IRQ_W-1:0];
				default:      ;
			endcase
			// overflow flag is cleared by software writing it low
			if (addr_i == ADDR_CON1) begin
				s_d.con1_r[CON1_OVF] = s_q.con1_r[CON1_OVF] & wdata_i[CON1_OVF];
			end
		end

		// i2c framing
		if (start_det) begin
			s_d.phase  = ST_ADDR;
			s_d.bitcnt = 4'h0;
			s_d.stat_r[STAT_START] = 1'b1;
			s_d.stat_r[STAT_STOP]  = 1'b0;
			if (sp_explicit || s_q.con3_r[CON3_SIE]) begin
				s_d.ist[IRQ_START] = 1'b1;
			end
		end else if (stop_det) begin
			s_d.phase  = ST_IDLE;
			s_d.bitcnt = 4'h0; // no stale count leaks into the next frame or mode
			s_d.stat_r[STAT_STOP]  = 1'b1;
			s_d.stat_r[STAT_START] = 1'b0;
			if (sp_explicit || s_q.con3_r[CON3_PIE]) begin
				s_d.ist[IRQ_STOP] = 1'b1;
			end
		end else if (i2c_slv && s_q.phase != ST_IDLE) begin
			// count rises: the fall that ends a start condition is no data bit
			if (scl_r) begin
				if (s_q.bitcnt < BIT_ACK) begin
					s_d.shift  = {s_q.shift[6:0], sda_s};
					s_d.bitcnt = s_q.bitcnt + 4'h1;
				end else if (s_q.bitcnt == BIT_ACK) begin
					s_d.bitcnt = BIT_ACK + 4'h1;     // ninth rise: acknowledge clock
					s_d.con3_r[CON3_ACKTIME] = 1'b0;
				end
			end
			// fall after the acknowledge clock closes the byte slot
			if (scl_f && s_q.bitcnt > BIT_ACK) begin
				s_d.bitcnt = 4'h0;
				s_d.phase  = ST_DATA;
			end
		end

		// byte end in i2c slave: hold and ack time
		if (byte_done) begin
			hold_evt = (s_q.phase == ST_ADDR) ? s_q.con3_r[CON3_AHE] : s_q.con3_r[CON3_DHE];
			if (s_q.con3_r[CON3_AHE] || s_q.con3_r[CON3_DHE]) begin
				s_d.con3_r[CON3_ACKTIME] = 1'b1;
			end
			if (hold_evt) begin
				s_d.con1_r[CON1_CKR] = 1'b0;
			end
			new_byte = 1'b1;
			nb       = s_q.shift;
		end

		// spi shifting
		if (spi_mode && sck_r) begin
			s_d.shift  = spi_word;
			s_d.bitcnt = (s_q.bitcnt == BIT_LAST) ? 4'h0 : s_q.bitcnt + 4'h1;
		end
		if (spi_byte) begin
			new_byte = 1'b1;
			nb       = spi_word;
		end

		// buffer load with overflow rules
		if (new_byte) begin
			s_d.ist[IRQ_BYTE] = 1'b1;
			if (s_q.stat_r[STAT_BF]) begin
				s_d.con1_r[CON1_OVF] = 1'b1;
				s_d.ist[IRQ_OVF] = 1'b1;
			end
			if (!s_q.stat_r[STAT_BF] || s_q.con3_r[CON3_BOE]) begin
				s_d.buf_r = nb;
				s_d.stat_r[STAT_BF] = 1'b1;
			end
		end
	end

	// register the state
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '{phase: ST_IDLE, bitcnt: 4'h0, shift: ZERO8, buf_r: ZERO8, add_r: ZERO8,
				msk_r: ZERO8, stat_r: ZERO8, con1_r: RST_CON1, con2_r: ZERO8, con3_r: ZERO8,
				ist: '0, imk: '0, rdata: ZERO8};
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign rdata_o    = s_q.rdata;
	// stretch: drive scl low while release bit is clear in slave mode
	assign scl_o      = 1'b0;
	assign scl_oe_n_o = ~(i2c_slv && !s_q.con1_r[CON1_CKR]);
	assign irq_o      = |(s_q.ist & s_q.imk);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_addr_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		byte_done && s_q.phase == ST_ADDR && s_q.con3_r[CON3_AHE] |=> !s_q.con1_r[CON1_CKR] && !scl_oe_n_o)
		else $error("address hold did not stretch");
	a_data_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		byte_done && s_q.phase == ST_DATA && s_q.con3_r[CON3_DHE] |=> !s_q.con1_r[CON1_CKR])
		else $error("data hold did not clear release");
	a_hold_ignored: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!i2c_slv |-> scl_oe_n_o)
		else $error("scl driven outside slave mode");
	a_spi_no_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		spi_byte && !(wr_i && addr_i == ADDR_CON1) |=> $stable(s_q.con1_r[CON1_CKR]))
		else $error("hold enables acted in spi mode");
	a_ovf_still: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		spi_byte && s_q.stat_r[STAT_BF] && s_q.con3_r[CON3_BOE] && !start_det
		|=> s_q.con1_r[CON1_OVF] && s_q.buf_r == $past(spi_word))
		else $error("overwrite mode lost byte or flag");
	a_stop_irq: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		stop_det && s_q.con3_r[CON3_PIE] |=> s_q.ist[IRQ_STOP])
		else $error("stop interrupt not raised");
	a_sp_explicit: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		start_det && sp_explicit |=> s_q.ist[IRQ_START])
		else $error("start not flagged in detecting mode");
	a_ack_time: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		byte_done && (s_q.con3_r[CON3_AHE] || s_q.con3_r[CON3_DHE]) |=> s_q.con3_r[CON3_ACKTIME])
		else $error("ack time not raised");
	a_release: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		wr_i && addr_i == ADDR_CON1 && wdata_i[CON1_CKR] && !byte_done |=> scl_oe_n_o)
		else $error("scl not released");
	a_read_lat: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		rd_i && addr_i == ADDR_CON2 && !wr_i |=> rdata_o == $past(s_q.con2_r))
		else $error("read data wrong");
endmodule

/* File: ssp_pkg.sv */
// package for the serial port hold-control block: register map, field positions, modes
// assumes byte-wide registers reached over a plain strobe port, one clock, async low reset
// Summary of operation
// - address hold stretches clock after eighth fall
// - data hold stretches clock after eighth fall
// - hold enables bits 1,0; ignored elsewhere
// - overwrite: flag overflow, still store newest
// - start/stop enables ignored in detecting modes
// - nine consecutive byte registers decoded
// - ack time high eighth fall when a hold enable is set, low ninth rise
// - stop enable raises interrupt on stop
package ssp_pkg;
	// register indices, byte addresses are the printed ones
	localparam logic [11:0] ADDR_BUF     = 12'h18C;
	localparam logic [11:0] ADDR_ADD     = 12'h18D;
	localparam logic [11:0] ADDR_MSK     = 12'h18E;
	localparam logic [11:0] ADDR_STAT    = 12'h18F;
	localparam logic [11:0] ADDR_CON1    = 12'h190;
	localparam logic [11:0] ADDR_CON2    = 12'h191;
	localparam logic [11:0] ADDR_CON3    = 12'h192;
	localparam logic [11:0] ADDR_IRQ_ST  = 12'h193;
	localparam logic [11:0] ADDR_IRQ_MSK = 12'h194;
	// control three fields
	localparam int CON3_ACKTIME = 7;
	localparam int CON3_PIE     = 6;
	localparam int CON3_SIE     = 5;
	localparam int CON3_BOE     = 4;
	localparam int CON3_AHE     = 1;
	localparam int CON3_DHE     = 0;
	localparam logic [7:0] CON3_WMASK = 8'h7F;
	// control one fields
	localparam int CON1_OVF = 6;
	localparam int CON1_CKR = 4;
	localparam logic [7:0] CON1_WMASK = 8'hBF;
	// status fields
	localparam int STAT_STOP = 4;
	localparam int STAT_START = 3;
	localparam int STAT_BF   = 0;
	// interrupt status bits
	localparam int IRQ_BYTE  = 0;
	localparam int IRQ_START = 1;
	localparam int IRQ_STOP  = 2;
	localparam int IRQ_OVF   = 3;
	localparam int IRQ_W     = 4;
	// modes of the mode-select field
	localparam logic [3:0] MODE_SPI_LAST  = 4'h5;
	localparam logic [3:0] MODE_SLV7      = 4'h6;
	localparam logic [3:0] MODE_SLV7_SP   = 4'hE;
	localparam logic [3:0] MODE_SLV7_SPX  = 4'h7;
	localparam logic [3:0] MODE_SLV10_SP  = 4'hF;
	localparam logic [3:0] MODE_SLV10     = 4'h9;
	localparam logic [3:0] BIT_LAST       = 4'h7;
	localparam logic [3:0] BIT_ACK        = 4'h8;
	localparam logic [7:0] RST_CON1       = 8'h10;
	localparam logic [7:0] ZERO8          = 8'h00;

	// i2c slave mode decode
	function automatic logic is_i2c_slave(input logic [3:0] m);
		is_i2c_slave = (m == MODE_SLV7) || (m == MODE_SLV10) || (m == MODE_SLV7_SP)
			|| (m == MODE_SLV7_SPX) || (m == MODE_SLV10_SP);
	endfunction

	// spi mode decode, modes 0 to 5
	function automatic logic is_spi(input logic [3:0] m);
		is_spi = (m <= MODE_SPI_LAST);
	endfunction
endpackage

/* File: ssp_sync.sv */
// three-flop pin synchroniser with agreement filter
// assumes an asynchronous pin; output changes once flops two and three agree
`timescale 1ns/1ns
module ssp_sync
	import ssp_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic s1_q;   // metastable catch
	logic s2_q;   // second stage
	logic s3_q;   // third stage
	logic lvl_q;  // filtered level

	// bus idles high, so reset to one
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			s3_q  <= 1'b1;
			lvl_q <= 1'b1;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// only an agreed value moves the level
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end
	assign level_o = lvl_q;
endmodule

/* File: ssp_edge.sv */
// rising/falling pulse detector on a synchronised level
// assumes the input is already in the clock domain
`timescale 1ns/1ns
module ssp_edge
	import ssp_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic lvl_i,
	output logic      rise_o,
	output logic      fall_o
);
	logic prev_q;  // last level

	// idle level of the bus is high
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= lvl_i;
		end
	end
	assign rise_o = lvl_i & ~prev_q;
	assign fall_o = ~lvl_i & prev_q;
endmodule

/* File: i2c_spi_peer.sv */
// i2c bus master and spi daisy-chain peer model driving the serial pins
// assumes scl_line_i is the wired scl level: pull-up, the device may hold it low
`timescale 1ns/1ns
module i2c_spi_peer (
	input  wire logic mclk_i,
	input  wire logic scl_line_i,
	output logic      scl_drv_o,
	output logic      sda_o,
	output logic      sck_o,
	output logic      sdi_o,
	output logic      stall_err_o
);
	localparam int PH = 10; // cycles per phase, above the pin filter latency

	// idle bus: both i2c lines released, spi clock parked
	initial begin
		scl_drv_o = 1'b1;
		sda_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
		stall_err_o = 1'b0;
	end

	// wait n bus phases
	task automatic ph(input int n);
		repeat (n * PH) @(posedge mclk_i);
	endtask

	// start: data falls while clock high
	task automatic start_cond();
		sda_o <= 1'b1;
		scl_drv_o <= 1'b1;
		ph(1);
		sda_o <= 1'b0;
		ph(1);
		scl_drv_o <= 1'b0;
		ph(1);
	endtask

	// eight bits msb first, stops after the eighth fall
	task automatic i2c_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			scl_drv_o <= 1'b0;
			ph(1);
			sda_o <= b[i];
			ph(1);
			scl_drv_o <= 1'b1;
			ph(1);
		end
		scl_drv_o <= 1'b0;
		ph(1);
	endtask

	// ninth clock; a real master waits while the slave stretches
	// data is released while the clock is low, or a low last bit would look like a stop
	task automatic ack_clock();
		int k;
		sda_o <= 1'b1;
		ph(1);
		scl_drv_o <= 1'b1;
		for (k = 0; k < 400 && scl_line_i !== 1'b1; k++) begin
			@(posedge mclk_i);
		end
		if (k == 400) begin
			stall_err_o <= 1'b1;
		end
		ph(1);
		scl_drv_o <= 1'b0;
		ph(1);
	endtask

	// stop: data rises while clock high
	task automatic stop_cond();
		sda_o <= 1'b0;
		ph(1);
		scl_drv_o <= 1'b1;
		ph(1);
		sda_o <= 1'b1;
		ph(1);
	endtask

	// spi byte msb first on rising sck; data line toggles after the frame
	task automatic spi_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sdi_o <= b[i];
			ph(1);
			sck_o <= 1'b1;
			ph(1);
			sck_o <= 1'b0;
		end
		sdi_o <= ~b[0];
		ph(1);
	endtask
endmodule

/* File: i2c_slave_hold_control_tb_top.sv */
// self-checking bench for the hold-control block with an i2c/spi peer model
// assumes the register map and field layout of ssp_pkg
`timescale 1ns/1ns
module i2c_slave_hold_control_tb_top;
	import ssp_pkg::*;
	logic        mclk_i;
	logic        nrst_i;
	logic [11:0] addr_i;
	logic [7:0]  wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [7:0]  rdata_o;
	logic        scl_o;
	logic        scl_oe_n_o;
	logic        irq_o;
	logic        scl_drv;
	logic        sda_w;
	logic        sck_w;
	logic        sdi_w;
	logic        stall_err;
	logic        scl_w;
	int          fail_count = 0;
	int          n_compared = 0;

	// wired scl: pull-up, master and stretching device both pull low
	assign scl_w = scl_drv & (scl_oe_n_o | scl_o);

	ssp_hold_ctrl ssp_hold_ctrl_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n_o), .sck_i(sck_w), .sdi_i(sdi_w), .irq_o(irq_o));
	i2c_spi_peer i2c_spi_peer_i (.mclk_i(mclk_i), .scl_line_i(scl_w), .scl_drv_o(scl_drv), .sda_o(sda_w),
		.sck_o(sck_w), .sdi_o(sdi_w), .stall_err_o(stall_err));

	// 100 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared tasks

	task automatic report_and_stop();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		// one idle edge, so a following call never reassigns the strobe in this step
		@(posedge mclk_i);
	endtask

	// read, data judged in the one cycle it stands, under a field mask
	task automatic rdm(input string n, input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		check(n, rdata_o & m, e);
		@(posedge mclk_i);
	endtask

	// pin levels, looked at once the last edge's updates landed
	task automatic chk_pins(input logic oe_n, input logic irq);
		#1;
		check("scl_oe_n", {7'h00, scl_oe_n_o}, {7'h00, oe_n});
		check("irq", {7'h00, irq_o}, {7'h00, irq});
		check("scl_o", {7'h00, scl_o}, 8'h00);
		// back onto the clock edge for whoever drives next
		@(posedge mclk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios

	task automatic t_reset_map();
		chk_pins(1'b1, 1'b0);
		rdm("con1", ADDR_CON1, 8'hFF, RST_CON1);
		wr(ADDR_ADD, 8'h5A);
		wr(ADDR_MSK, 8'hC3);
		wr(ADDR_CON3, 8'hFF);
		rdm("addr", ADDR_ADD, 8'hFF, 8'h5A);
		rdm("mask", ADDR_MSK, 8'hFF, 8'hC3);
		rdm("con3", ADDR_CON3, 8'hFF, 8'h7F);
		rdm("unmapped", 12'h18B, 8'hFF, 8'h00);
		wr(ADDR_CON3, 8'h00);
	endtask

	task automatic t_i2c_hold();
		wr(ADDR_CON1, 8'h16);
		wr(ADDR_CON3, 8'h02);
		i2c_spi_peer_i.start_cond();
		i2c_spi_peer_i.i2c_byte(8'hA5);
		chk_pins(1'b0, 1'b0);
		rdm("release", ADDR_CON1, 8'h10, 8'h00);
		rdm("acktime", ADDR_CON3, 8'h80, 8'h80);
		rdm("full", ADDR_STAT, 8'h01, 8'h01);
		rdm("buf", ADDR_BUF, 8'hFF, 8'hA5);
		wr(ADDR_CON1, 8'h16);
		chk_pins(1'b1, 1'b0);
		i2c_spi_peer_i.ack_clock();
		rdm("acktime", ADDR_CON3, 8'h80, 8'h00);
		i2c_spi_peer_i.i2c_byte(8'h3C);
		chk_pins(1'b1, 1'b0);
		rdm("buf", ADDR_BUF, 8'hFF, 8'h3C);
		i2c_spi_peer_i.ack_clock();
		wr(ADDR_CON3, 8'h01);
		i2c_spi_peer_i.i2c_byte(8'hC3);
		chk_pins(1'b0, 1'b0);
		rdm("buf", ADDR_BUF, 8'hFF, 8'hC3);
		wr(ADDR_CON1, 8'h16);
		chk_pins(1'b1, 1'b0);
		i2c_spi_peer_i.ack_clock();
		i2c_spi_peer_i.stop_cond();
	endtask

	task automatic t_spi_overwrite();
		wr(ADDR_CON1, 8'h10);
		wr(ADDR_CON3, 8'h13);
		wr(ADDR_IRQ_MSK, 8'h08);
		wr(ADDR_IRQ_ST, 8'h0F);
		i2c_spi_peer_i.spi_byte(8'h11);
		i2c_spi_peer_i.spi_byte(8'h22);
		chk_pins(1'b1, 1'b1);
		rdm("ovf", ADDR_CON1, 8'h50, 8'h50);
		rdm("buf", ADDR_BUF, 8'hFF, 8'h22);
		wr(ADDR_IRQ_ST, 8'h0F);
		chk_pins(1'b1, 1'b0);
		wr(ADDR_IRQ_MSK, 8'h00);
		wr(ADDR_CON1, 8'h10);
		i2c_spi_peer_i.spi_byte(8'h33);
		rdm("irqst", ADDR_IRQ_ST, 8'h0F, 8'h01);
		chk_pins(1'b1, 1'b0);
		rdm("buf", ADDR_BUF, 8'hFF, 8'h33);
	endtask

	task automatic t_stop_irq();
		wr(ADDR_CON1, 8'h16);
		wr(ADDR_CON3, 8'h40);
		wr(ADDR_IRQ_ST, 8'h0F);
		wr(ADDR_IRQ_MSK, 8'h04);
		i2c_spi_peer_i.start_cond();
		i2c_spi_peer_i.i2c_byte(8'h5A);
		chk_pins(1'b1, 1'b0);
		rdm("buf", ADDR_BUF, 8'hFF, 8'h5A);
		i2c_spi_peer_i.ack_clock();
		i2c_spi_peer_i.stop_cond();
		chk_pins(1'b1, 1'b1);
		wr(ADDR_IRQ_ST, 8'h0F);
		wr(ADDR_CON3, 8'h00);
		i2c_spi_peer_i.start_cond();
		i2c_spi_peer_i.stop_cond();
		rdm("stopst", ADDR_IRQ_ST, 8'h04, 8'h00);
		wr(ADDR_CON1, 8'h17);
		i2c_spi_peer_i.start_cond();
		i2c_spi_peer_i.stop_cond();
		rdm("stopst", ADDR_IRQ_ST, 8'h04, 8'h04);
		chk_pins(1'b1, 1'b1);
		// ten-bit slave with detection built in: enables still off
		wr(ADDR_IRQ_ST, 8'h0F);
		wr(ADDR_CON1, 8'h1F);
		i2c_spi_peer_i.start_cond();
		i2c_spi_peer_i.stop_cond();
		rdm("stopst10", ADDR_IRQ_ST, 8'h04, 8'h04);
	endtask

	// reset in mid-run: control back to its reset value, events gone
	task automatic t_mid_reset();
		wr(ADDR_CON1, 8'h17);
		nrst_i <= 1'b0;
		@(posedge mclk_i);
		nrst_i <= 1'b1;
		@(posedge mclk_i);
		rdm("con1_rst", ADDR_CON1, 8'hFF, RST_CON1);
		rdm("irqst_rst", ADDR_IRQ_ST, 8'h0F, 8'h00);
		chk_pins(1'b1, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence: reset three cycles, then the scenarios
	initial begin
		nrst_i = 1'b0;
		addr_i = 12'h000;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		repeat (3) @(posedge mclk_i);
		nrst_i <= 1'b1;
		@(posedge mclk_i);
		t_reset_map();
		t_i2c_hold();
		t_spi_overwrite();
		t_stop_irq();
		t_mid_reset();
		check("stall", {7'h00, stall_err}, 8'h00);
		report_and_stop();
	end

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge mclk_i);
		fail_count++;
		report_and_stop();
	end
endmodule
